// ---- hw/sbc_rx_out.sv ----
// Receive output stage: signal-present flag, parallel words and paired byte clocks.
`timescale 1ns/100ps
`default_nettype none
module sbc_rx_out
    import sbc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Line side: comparator result and recovered serial bits.
    input wire logic line_above_thresh,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    // Host control pin.
    input wire logic comma_align_enable,
    // Host outputs.
    output logic line_signal_present,
    output logic [WORD_W-1:0] rx_word,
    output logic [1:0] rx_byte_clk,
    output logic comma_found
);
    // Synchronised pins.
    logic [1:0] pin_raw;
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic sig_sync;
    logic en_sync;
    // Output stage.
    logic present_q;
    logic [WORD_W-1:0] word_q;
    logic comma_word_q;
    logic comma_q;
    // Byte-clock pair.
    logic clk0_q;
    logic clk1_q;
    logic take_word;
    logic take_comma;
    logic early_drop;
    logic advance;

    // The pair either waits for a word or owes it one clock step.
    typedef enum logic {
        PAIR_IDLE = 1'h0,
        PAIR_ARMED = 1'h1
    } sbc_pair_state_t;

    sbc_pair_state_t pair_q;
    sbc_pair_state_t pair_d;

    sbc_word_if wif ();

    // High when an assembled word arrives while the line is present.
    function automatic logic word_arrives(
        input logic valid,
        input logic line_ok
    );
        return valid && line_ok;
    endfunction

    // High when an arriving word is a comma and alignment is switched in.
    function automatic logic comma_arrives(
        input logic valid,
        input logic line_ok,
        input logic comma,
        input logic align_on
    );
        return word_arrives(valid, line_ok) && comma && align_on;
    endfunction

    // Both pins are asynchronous to clk, so each passes two flip-flops before use;
    // bit 0 carries the comparator and bit 1 the align enable.
    assign pin_raw = {comma_align_enable, line_above_thresh};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_q <= 2'h0;
            pin_sync_q <= 2'h0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Only the second stage of each synchroniser is read by logic.
    assign sig_sync = pin_sync_q[0];
    assign en_sync = pin_sync_q[1];

    // Signal-present trails the comparator pin by three clock edges.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            present_q <= 1'h0;
        end else begin
            present_q <= sig_sync;
        end
    end

    // Bits are assembled into words here, and commas reset the framing.
    sbc_deser u_deser (
        .clk(clk),
        .sys_rst(sys_rst),
        .bit_in(rx_bit),
        .bit_valid(rx_bit_valid),
        .align_en(en_sync),
        .line_ok(sig_sync),
        .out(wif.src)
    );

    // Words are taken only while the synchronised line is present.
    assign take_word = word_arrives(wif.word_valid, sig_sync);
    assign take_comma = comma_arrives(wif.word_valid, sig_sync, wif.comma, en_sync);
    // A comma that finds clock one already high drops it first, so that its next
    // rising edge still meets the comma word. Clock zero then rises with the comma
    // word as well, and a host that takes both edges sees that word twice.
    assign early_drop = take_comma && clk1_q;
    // The owed clock step is taken in the cycle after the word lands.
    assign advance = (pair_q == PAIR_ARMED) && !take_word;

    // Data is set up one cycle ahead of the byte clock edge that captures it, except the clock-zero edge of an early drop.
    // Loss of signal overrides any word in flight and shows all ones.
    always_ff @(posedge clk) begin
        if (sys_rst || !sig_sync) begin
            word_q <= LOSS_WORD;
        end else if (take_word) begin
            word_q <= wif.word;
        end
    end

    // The comma mark is kept only while alignment is switched in.
    always_ff @(posedge clk) begin
        if (sys_rst || !sig_sync) begin
            comma_word_q <= 1'h0;
        end else if (take_word) begin
            comma_word_q <= wif.comma && en_sync;
        end
    end

    // A taken word arms the pair; the following cycle without a word steps it.
    always_comb begin
        pair_d = pair_q;
        case (pair_q)
            PAIR_IDLE: begin
                if (take_word) begin
                    pair_d = PAIR_ARMED;
                end
            end
            PAIR_ARMED: begin
                if (!take_word) begin
                    pair_d = PAIR_IDLE;
                end
            end
            default: begin
                pair_d = PAIR_IDLE;
            end
        endcase
    end

    // The pair state resets idle, with no clock step owed.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pair_q <= PAIR_IDLE;
        end else begin
            pair_q <= pair_d;
        end
    end

    // The pair is stepped from clk once per word, so its rate is half the word
    // rate of the stream; rising edges alternate between the two clocks.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk0_q <= BYTE_CLK0_RESET;
        end else if (early_drop) begin
            clk0_q <= 1'h1;
        end else if (advance) begin
            if (comma_word_q) begin
                clk0_q <= 1'h0;
            end else begin
                clk0_q <= ~clk0_q;
            end
        end
    end

    // Clock one is always the complement of clock zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk1_q <= ~BYTE_CLK0_RESET;
        end else if (early_drop) begin
            clk1_q <= 1'h0;
        end else if (advance) begin
            if (comma_word_q) begin
                clk1_q <= 1'h1;
            end else begin
                clk1_q <= clk0_q;
            end
        end
    end

    // Comma-found stands with the comma word and is forced low when disabled.
    // It changes with the clock edge, so the host reads it together with the word.
    always_ff @(posedge clk) begin
        if (sys_rst || !en_sync) begin
            comma_q <= 1'h0;
        end else if (advance) begin
            comma_q <= comma_word_q;
        end
    end

    // Every output is a flop, so the host sees no decode glitches.
    assign line_signal_present = present_q;
    assign rx_word = word_q;
    assign rx_byte_clk = {clk1_q, clk0_q};
    assign comma_found = comma_q;
endmodule
`default_nettype wire

// ---- hw/sbc_pkg.sv ----
// Shared constants for the receive byte-clock output block.
package sbc_pkg;
    localparam int WORD_W = 10;
    localparam logic [3:0] WORD_BITS = 4'hA;
    // Comma pattern 0011111XXX in arrival order; the first arrival sits in bit 0.
    localparam logic [6:0] COMMA_BITS = 7'h7C;
    // After a comma's seven leading bits, three bits remain in the word.
    localparam logic [3:0] COMMA_BIT_CNT = 4'h7;
    localparam logic [WORD_W-1:0] LOSS_WORD = 10'h3FF;
    localparam int SIG_THRESH_MV = 50;
    localparam int BYTE_CLK_KHZ = 62500;
    localparam int BYTE_CLK_PHASE_DEG = 180;
    localparam int SYS_CLK_KHZ = 50000;
    localparam logic BYTE_CLK0_RESET = 1'h0;
endpackage

// ---- hw/sbc_word_if.sv ----
// Carrier for assembled code words between deserializer and output stage.
`timescale 1ns/100ps
`default_nettype none
interface sbc_word_if;
    import sbc_pkg::*;
    logic [WORD_W-1:0] word;
    logic word_valid;
    logic comma;
    modport src (output word, output word_valid, output comma);
    modport dst (input word, input word_valid, input comma);
endinterface
`default_nettype wire

// ---- hw/sbc_deser.sv ----
// Serial-to-parallel word assembly with comma-based boundary alignment.
`timescale 1ns/100ps
`default_nettype none
module sbc_deser
    import sbc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Recovered serial stream and controls.
    input wire logic bit_in,
    input wire logic bit_valid,
    input wire logic align_en,
    input wire logic line_ok,
    // Assembled words.
    sbc_word_if.src out
);
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] shift_d;
    logic [3:0] cnt_q;
    logic comma_q;
    logic comma_hit;

    // New bits enter at the top, so the first bit of a word ends in bit 0.
    assign shift_d = {bit_in, shift_q[WORD_W-1:1]};
    assign comma_hit = align_en && (shift_d[WORD_W-1:3] == COMMA_BITS);

    always_ff @(posedge clk) begin
        if (sys_rst || !line_ok) begin
            shift_q <= '0;
        end else if (bit_valid) begin
            shift_q <= shift_d;
        end
    end

    // A comma restarts the word count so the comma heads the next word.
    always_ff @(posedge clk) begin
        if (sys_rst || !line_ok) begin
            cnt_q <= '0;
            comma_q <= 1'h0;
        end else if (bit_valid) begin
            if (comma_hit) begin
                cnt_q <= COMMA_BIT_CNT;
                comma_q <= 1'h1;
            end else if (cnt_q == WORD_BITS - 4'h1) begin
                cnt_q <= '0;
                comma_q <= 1'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out.word <= '0;
            out.word_valid <= 1'h0;
            out.comma <= 1'h0;
        end else begin
            out.word_valid <= line_ok && bit_valid && !comma_hit
                              && (cnt_q == WORD_BITS - 4'h1);
            out.word <= shift_d;
            out.comma <= comma_q && align_en;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/sbc_rx_out_props.sv ----
// Concurrent checks of the ports of the receive byte-clock output block.
`timescale 1ns/100ps
`default_nettype none
module sbc_rx_out_props
    import sbc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic line_above_thresh,
    input wire logic comma_align_enable,
    input wire logic line_signal_present,
    input wire logic [WORD_W-1:0] rx_word,
    input wire logic [1:0] rx_byte_clk,
    input wire logic comma_found
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    clk_pair_a: assert property (rx_byte_clk[0] ^ rx_byte_clk[1]) else $error("pair");
    loss_flag_a: assert property (!line_above_thresh [*4] |=> !line_signal_present)
        else $error("flag low");
    present_flag_a: assert property (line_above_thresh [*4] |=> line_signal_present)
        else $error("flag high");
    loss_word_a: assert property (!line_above_thresh [*4] |=> rx_word == LOSS_WORD)
        else $error("loss word");
    word_clock_a: assert property ($changed(rx_word) && rx_word != LOSS_WORD
        && line_signal_present |=> $changed(rx_byte_clk)) else $error("no edge");
    comma_edge_a: assert property ($rose(comma_found) |-> $rose(rx_byte_clk[1]))
        else $error("comma edge");
    comma_bits_a: assert property ($rose(rx_byte_clk[1]) && comma_found
        |-> rx_word[6:0] == COMMA_BITS) else $error("comma bits");
    comma_off_a: assert property (!comma_align_enable [*4] |=> !comma_found)
        else $error("comma off");
endmodule
bind sbc_rx_out sbc_rx_out_props props_u (.clk(clk), .sys_rst(sys_rst),
    .line_above_thresh(line_above_thresh), .comma_align_enable(comma_align_enable),
    .line_signal_present(line_signal_present), .rx_word(rx_word),
    .rx_byte_clk(rx_byte_clk), .comma_found(comma_found));
`default_nettype wire

// ---- testbench/sbc_host_model.sv ----
// Host capture model: takes each word at a rising edge of either byte clock.
`timescale 1ns/100ps
`default_nettype none
module sbc_host_model
    import sbc_pkg::*;
(
    input wire logic clk,
    input wire logic [WORD_W-1:0] rx_word,
    input wire logic [1:0] rx_byte_clk,
    output logic cap_stb,
    output logic [WORD_W:0] cap
);
    logic [1:0] clk_q;
    always_ff @(posedge clk) begin
        clk_q <= rx_byte_clk;
        cap_stb <= |(rx_byte_clk & ~clk_q);
        cap <= {rx_byte_clk[1], rx_word};
    end
endmodule
`default_nettype wire

// ---- testbench/sbc_rx_out_tb.sv ----
// Testbench for the receive byte-clock output block.
`timescale 1ns/100ps
`default_nettype none
module sbc_rx_out_tb;
    import sbc_pkg::*;
    logic clk = 1'h0, sys_rst = 1'h1, lat = 1'h0, rx_bit = 1'h0, rx_bit_valid = 1'h0;
    logic cae = 1'h0;
    logic lsp, cf, cap_stb;
    logic [WORD_W-1:0] rx_word;
    logic [1:0] bclk;
    logic [WORD_W:0] cap;
    logic [WORD_W:0] q[$];
    int bad_count = 0, n_compared = 0, cyc = 0;
    always #10 clk = ~clk;
    sbc_rx_out dut_u (.clk(clk), .sys_rst(sys_rst), .line_above_thresh(lat), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .comma_align_enable(cae), .line_signal_present(lsp),
        .rx_word(rx_word), .rx_byte_clk(bclk), .comma_found(cf));
    sbc_host_model host_u (.clk(clk), .rx_word(rx_word), .rx_byte_clk(bclk),
        .cap_stb(cap_stb), .cap(cap));
    always @(posedge clk) begin
        cyc++;
        if (cap_stb) q.push_back(cap);
        if (cyc > 3000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [WORD_W:0] e, input logic [WORD_W:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waiting cycles carry no serial bits; back-to-back sends keep the strobe up.
    task automatic tick(input int n);
        rx_bit_valid <= 1'h0;
        repeat (n) @(posedge clk);
    endtask
    // Serial bits go out first-bit-first, one per cycle.
    task automatic send(input logic [WORD_W-1:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            rx_bit <= w[i];
            rx_bit_valid <= 1'h1;
            @(posedge clk);
        end
    endtask
    // A comma arriving off the word boundary must be re-framed onto byte clock one.
    task automatic test_align;
        q.delete();
        send(10'h3FF, 10);
        send(10'h3FF, 5);
        send(10'h2FC, 10);
        send(10'h155, 10);
        send(10'h2AA, 10);
        tick(8);
        chk("comma word", {1'h1, 10'h2FC}, q[$-2]);
        chk("word a", {1'h0, 10'h155}, q[$-1]);
        chk("word b", {1'h1, 10'h2AA}, q[$]);
        $display("test_align end");
    endtask
    task automatic test_noalign;
        cae <= 1'h0;
        tick(4);
        q.delete();
        send(10'h3FF, 5);
        send(10'h2FC, 10);
        send(10'h3FF, 5);
        tick(8);
        chk("no align a", {1'h0, 10'h39F}, q[$-1]);
        chk("no align b", {1'h1, 10'h3F7}, q[$]);
        chk("comma flag", 11'h000, {10'h000, cf});
        $display("test_noalign end");
    endtask
    // Signal drops in mid-word, then returns.
    task automatic test_loss;
        send(10'h155, 4);
        lat <= 1'h0;
        tick(6);
        chk("present", 11'h000, {10'h000, lsp});
        chk("loss word", {1'h0, LOSS_WORD}, {1'h0, rx_word});
        lat <= 1'h1;
        tick(6);
        chk("present", 11'h001, {10'h000, lsp});
        $display("test_loss end");
    endtask
    initial begin
        tick(8);
        sys_rst <= 1'h0;
        lat <= 1'h1;
        cae <= 1'h1;
        tick(6);
        test_align();
        test_noalign();
        test_loss();
        stop_test();
    end
endmodule
`default_nettype wire
